//--- logic/dcsm_top.sv
// Dual channel standstill monitor: supervision, fault latch and relay drive
//
// Functional notes
// - Two pick-up channels are measured continuously to derive the motion frequency.
// - Measured frequency is compared all the time against the selected switch point.
// - Relays energise when frequency falls 5 % below the switch point.
// - Relays release when frequency rises 5 % above the switch point.
// - Four switch points, 0.2, 0.5, 1 or 2 Hz, chosen by bridging.
// - Each channel drives its own output relay.
// - Combined standstill contact closes only with both relays energised.
// - Safe state is both contacts open, and it is the default.
// - Fault status output high in run when error free, low on an error and during self-test.
// - Self-test starts whenever supply power is applied.
// - About six seconds of self-diagnosis precede normal operation.
// - Diverging channel pulse sequences raise an error and force the safe state.
// - Both sensors inactive together raises an error and forces the safe state.
// - A latched error clears only by cycling power.
`timescale 1ns/10ps
module dcsm_top #(
    parameter int unsigned TICK_CYC       = dcsm_pkg::TICK_CYC,       // Cycles per tick
    parameter int unsigned SELFTEST_TICKS = dcsm_pkg::SELFTEST_TICKS  // Self-test length
) (
    input  wire logic       mclk_i,                 // 200 MHz clock
    input  wire logic       sys_rst_i,              // Power-on reset, active high
    input  wire logic       pulse_one_i,            // Pick-up channel one, high = damped
    input  wire logic       pulse_two_i,            // Pick-up channel two, high = damped
    input  wire logic [1:0] sp_sel_i,               // Switch point bridge code
    output logic            first_output_relay_o,   // Relay channel one energised
    output logic            second_output_relay_o,  // Relay channel two energised
    output logic            standstill_contact_o,   // Series contact closed
    output logic            fault_status_output_o,  // High = no error
    output logic            ready_o,                // Self-diagnosis completed and no error
    output logic [2:0]      err_cause_o             // Latched error causes
);
    import dcsm_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    dcsm_state_t              state_q;
    logic [TICK_W-1:0]        tick_cnt_q;
    logic                     tick_q;
    logic [CNT_W-1:0]         st_cnt_q;
    logic [1:0]               sp_q;
    logic [CNT_W-1:0]         on_thr;
    logic [CNT_W-1:0]         off_thr;
    logic                     ch1_edge;
    logic                     ch2_edge;
    logic                     ch1_slow;
    logic                     ch2_slow;
    logic [CNT_W-1:0]         channel_one_frequency;
    logic [CNT_W-1:0]         channel_two_frequency;
    logic signed [DIFF_W-1:0] diff_q;
    logic [TICK_W-1:0]        low_cnt_q;
    logic [ERR_W-1:0]         err_now;
    logic                     running;
    logic                     rel1_d;
    logic                     rel2_d;

    // ==========================================================
    // Time base
    // ==========================================================
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= TICK_W'(TICK_CYC - 1)) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q     <= 1'b0;
        end
    end

    // ==========================================================
    // Switch point selection
    // ==========================================================
    // The bridge is sampled during self-test; a later change is an error
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sp_q <= SEL_0P2HZ;
        end else if (state_q == ST_SELFTEST) begin
            sp_q <= sp_sel_i;
        end
    end

    always_comb begin
        if (sp_q == SEL_0P2HZ) begin
            on_thr  = ON_THR0;
            off_thr = OFF_THR0;
        end else if (sp_q == SEL_0P5HZ) begin
            on_thr  = ON_THR1;
            off_thr = OFF_THR1;
        end else if (sp_q == SEL_1HZ) begin
            on_thr  = ON_THR2;
            off_thr = OFF_THR2;
        end else begin
            on_thr  = ON_THR3;
            off_thr = OFF_THR3;
        end
    end

    // ==========================================================
    // Channels
    // ==========================================================
    dcsm_chan u_chan_one (
        .clk_i     (mclk_i),
        .rst_i     (sys_rst_i),
        .tick_i    (tick_q),
        .pulse_i   (pulse_one_i),
        .on_thr_i  (on_thr),
        .off_thr_i (off_thr),
        .edge_o    (ch1_edge),
        .slow_o    (ch1_slow),
        .period_o  (channel_one_frequency)
    );

    dcsm_chan u_chan_two (
        .clk_i     (mclk_i),
        .rst_i     (sys_rst_i),
        .tick_i    (tick_q),
        .pulse_i   (pulse_two_i),
        .on_thr_i  (on_thr),
        .off_thr_i (off_thr),
        .edge_o    (ch2_edge),
        .slow_o    (ch2_slow),
        .period_o  (channel_two_frequency)
    );

    assign running = (state_q == ST_RUN);

    // ==========================================================
    // Pulse comparison
    // ==========================================================
    // Edges of the two cams interleave; a lost sensor lets the
    // difference run away instead of reading as a slow axis
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !running) begin
            diff_q <= 4'sh0;
        end else if (ch1_edge && !ch2_edge && (diff_q <= DIVERGE_MAX)) begin
            diff_q <= diff_q + 4'sh1;
        end else if (ch2_edge && !ch1_edge && (diff_q >= -DIVERGE_MAX)) begin
            diff_q <= diff_q - 4'sh1;
        end
    end

    // ==========================================================
    // Both-gap supervision, short filter against edge overlap
    // ==========================================================
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !running || pulse_one_i || pulse_two_i) begin
            low_cnt_q <= 16'h0000;
        end else if (low_cnt_q < TICK_W'(BOTH_LOW_CYC)) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end

    always_comb begin
        err_now              = '0;
        err_now[ERR_DIVERGE] = running && ((diff_q > DIVERGE_MAX) ||
                                           (diff_q < -DIVERGE_MAX));
        err_now[ERR_BOTHLOW] = running && (low_cnt_q >= TICK_W'(BOTH_LOW_CYC));
        err_now[ERR_SPCHG]   = running && (sp_sel_i != sp_q);
    end

    // ==========================================================
    // Operating state: self-test, run, latched fault
    // ==========================================================
    // Only the power-on reset leaves the fault state
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_q  <= ST_SELFTEST;
            st_cnt_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                ST_SELFTEST: begin
                    if (st_cnt_q >= CNT_W'(SELFTEST_TICKS)) begin
                        state_q <= ST_RUN;
                    end else if (tick_q) begin
                        st_cnt_q <= st_cnt_q + 32'h0000_0001;
                    end
                end
                ST_RUN: begin
                    if (err_now != '0) begin
                        state_q <= ST_FAULT;
                    end
                end
                ST_FAULT: begin
                    state_q <= ST_FAULT;
                end
                default: begin
                    state_q <= ST_FAULT;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            err_cause_o <= 3'h0;
        end else begin
            err_cause_o <= err_cause_o | err_now;
        end
    end

    // ==========================================================
    // Relays, series contact and status outputs
    // ==========================================================
    // The error term is used directly so the relays drop in the same
    // cycle the fault state is entered
    assign rel1_d = running && (err_now == '0) && ch1_slow;
    assign rel2_d = running && (err_now == '0) && ch2_slow;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            first_output_relay_o  <= 1'b0;
            second_output_relay_o <= 1'b0;
            standstill_contact_o  <= 1'b0;
            fault_status_output_o <= 1'b0;
            ready_o               <= 1'b0;
        end else begin
            first_output_relay_o  <= rel1_d;
            second_output_relay_o <= rel2_d;
            standstill_contact_o  <= rel1_d && rel2_d;
            fault_status_output_o <= running && (err_now == '0);
            ready_o               <= running && (err_now == '0);
        end
    end

endmodule

//--- common/dcsm_pkg.sv
// Constants shared by the dual channel standstill monitor
package dcsm_pkg;

    // ==========================================================
    // Clock and measurement time base
    // ==========================================================
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned TICK_HZ       = 100_000;              // 10 us tick
    localparam int unsigned TICK_CYC      = CLK_HZ / TICK_HZ;     // 2000 cycles
    localparam int unsigned TICK_W        = 16;
    localparam int unsigned CNT_W         = 32;

    // ==========================================================
    // Self-diagnosis after power-up
    // ==========================================================
    localparam int unsigned SELFTEST_MS    = 6000;
    localparam int unsigned SELFTEST_TICKS = SELFTEST_MS * (TICK_HZ / 1000);

    // ==========================================================
    // Switch points in centihertz, selected by the bridge code
    // ==========================================================
    localparam logic [1:0] SEL_0P2HZ = 2'h0;
    localparam logic [1:0] SEL_0P5HZ = 2'h1;
    localparam logic [1:0] SEL_1HZ   = 2'h2;
    localparam logic [1:0] SEL_2HZ   = 2'h3;
    localparam int unsigned SP0_CHZ  = 20;
    localparam int unsigned SP1_CHZ  = 50;
    localparam int unsigned SP2_CHZ  = 100;
    localparam int unsigned SP3_CHZ  = 200;

    // Hysteresis in percent of the switch point
    localparam int unsigned HYST_LO_PCT = 95;
    localparam int unsigned HYST_HI_PCT = 105;
    // Tick count of one period at 1 centihertz times 100 percent
    localparam int unsigned PER_K       = TICK_HZ * 100 * 100;

    // Period in ticks at or above which the speed is below 95 % (ceiling)
    localparam logic [CNT_W-1:0] ON_THR0  = CNT_W'((PER_K + SP0_CHZ*HYST_LO_PCT - 1)
                                                   / (SP0_CHZ*HYST_LO_PCT));
    localparam logic [CNT_W-1:0] ON_THR1  = CNT_W'((PER_K + SP1_CHZ*HYST_LO_PCT - 1)
                                                   / (SP1_CHZ*HYST_LO_PCT));
    localparam logic [CNT_W-1:0] ON_THR2  = CNT_W'((PER_K + SP2_CHZ*HYST_LO_PCT - 1)
                                                   / (SP2_CHZ*HYST_LO_PCT));
    localparam logic [CNT_W-1:0] ON_THR3  = CNT_W'((PER_K + SP3_CHZ*HYST_LO_PCT - 1)
                                                   / (SP3_CHZ*HYST_LO_PCT));
    // Period in ticks at or below which the speed is above 105 % (strict)
    localparam logic [CNT_W-1:0] OFF_THR0 = CNT_W'((PER_K - 1) / (SP0_CHZ*HYST_HI_PCT));
    localparam logic [CNT_W-1:0] OFF_THR1 = CNT_W'((PER_K - 1) / (SP1_CHZ*HYST_HI_PCT));
    localparam logic [CNT_W-1:0] OFF_THR2 = CNT_W'((PER_K - 1) / (SP2_CHZ*HYST_HI_PCT));
    localparam logic [CNT_W-1:0] OFF_THR3 = CNT_W'((PER_K - 1) / (SP3_CHZ*HYST_HI_PCT));

    // ==========================================================
    // Sensor supervision
    // ==========================================================
    localparam int unsigned BOTH_LOW_NS  = 1000;
    localparam int unsigned BOTH_LOW_CYC = (BOTH_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIFF_W       = 4;
    localparam logic signed [DIFF_W-1:0] DIVERGE_MAX = 4'sh2;

    // Error cause bits
    localparam int unsigned ERR_W       = 3;
    localparam int unsigned ERR_DIVERGE = 0;
    localparam int unsigned ERR_BOTHLOW = 1;
    localparam int unsigned ERR_SPCHG   = 2;

    typedef enum logic [1:0] {
        ST_SELFTEST,
        ST_RUN,
        ST_FAULT
    } dcsm_state_t;

endpackage

//--- logic/dcsm_chan.sv
// One pick-up channel: period measurement and hysteresis standstill flag
`timescale 1ns/10ps
module dcsm_chan (
    input  wire logic                       clk_i,      // System clock
    input  wire logic                       rst_i,      // Synchronous reset
    input  wire logic                       tick_i,     // Time base tick
    input  wire logic                       pulse_i,    // Sensor level
    input  wire logic [dcsm_pkg::CNT_W-1:0] on_thr_i,   // Slow threshold, ticks
    input  wire logic [dcsm_pkg::CNT_W-1:0] off_thr_i,  // Fast threshold, ticks
    output logic                            edge_o,     // Rising edge pulse
    output logic                            slow_o,     // Below switch point
    output logic [dcsm_pkg::CNT_W-1:0]      period_o    // Last full period
);
    import dcsm_pkg::*;

    logic                 pulse_q;
    logic                 rise;
    logic [CNT_W-1:0]     cnt_q;

    assign rise = pulse_i & ~pulse_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_q <= 1'b0;
            edge_o  <= 1'b0;
        end else begin
            pulse_q <= pulse_i;
            edge_o  <= rise;
        end
    end

    // ==========================================================
    // Period counter, saturating so a stopped axis stays slow
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q    <= 32'h0000_0000;
            period_o <= 32'h0000_0000;
        end else if (rise) begin
            cnt_q    <= 32'h0000_0000;
            period_o <= cnt_q;
        end else if (tick_i && (cnt_q != {CNT_W{1'b1}})) begin
            cnt_q    <= cnt_q + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Hysteresis: the open gap also counts, so no edge is needed to go slow
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_o <= 1'b0;
        end else if (cnt_q >= on_thr_i) begin
            slow_o <= 1'b1;
        end else if (rise && (cnt_q <= off_thr_i)) begin
            slow_o <= 1'b0;
        end
    end

endmodule

//--- testbench/dcsm_props.sv
// Port checker for the standstill monitor top
`timescale 1ns/10ps
module dcsm_props #(
    parameter int unsigned TICK_CYC       = 1,  // Cycles per tick
    parameter int unsigned SELFTEST_TICKS = 1   // Self-test ticks
) (
    input wire logic       mclk_i,                 // Clock
    input wire logic       sys_rst_i,              // Reset
    input wire logic       pulse_one_i,            // Pick-up one
    input wire logic       pulse_two_i,            // Pick-up two
    input wire logic [1:0] sp_sel_i,               // Bridge code
    input wire logic       first_output_relay_o,   // Relay one
    input wire logic       second_output_relay_o,  // Relay two
    input wire logic       standstill_contact_o,   // Contact
    input wire logic       fault_status_output_o,  // Status
    input wire logic       ready_o,                // Ready
    input wire logic [2:0] err_cause_o             // Causes
);
    import dcsm_pkg::*;
    localparam int unsigned ST_CYC = SELFTEST_TICKS * TICK_CYC;
    logic [31:0] age_q;
    logic [31:0] gap_q;
    logic        p1_q;
    logic        p2_q;
    logic [5:0]  e1_q;
    logic [5:0]  e2_q;
    function automatic logic [31:0] on_thr(input logic [1:0] s);
        return s == 2'h0 ? ON_THR0 : s == 2'h1 ? ON_THR1 : s == 2'h2 ? ON_THR2 : ON_THR3;
    endfunction
    always_ff @(posedge mclk_i) begin
        age_q <= sys_rst_i ? 32'h0 : age_q + 32'h1;
    end
    // Edge history lets a relay release be traced to a recent pick-up edge
    always_ff @(posedge mclk_i) begin
        p1_q <= pulse_one_i;
        p2_q <= pulse_two_i;
        e1_q <= {e1_q[4:0], pulse_one_i & ~p1_q};
        e2_q <= {e2_q[4:0], pulse_two_i & ~p2_q};
        gap_q <= (sys_rst_i || (pulse_one_i && !p1_q)) ? 32'h0 : gap_q + 32'h1;
    end
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    quiet_selftest_a: assert property (
        age_q < ST_CYC |-> !fault_status_output_o && !first_output_relay_o
    ) else $error("output active in self-test");
    series_contact_a: assert property (
        standstill_contact_o |-> first_output_relay_o && second_output_relay_o
    ) else $error("contact closed without both relays");
    status_clean_a: assert property (
        fault_status_output_o |-> err_cause_o == 3'h0 && ready_o
    ) else $error("status high with an error");
    fault_safe_a: assert property (
        err_cause_o != 3'h0 |-> ##1 !(first_output_relay_o || second_output_relay_o
        || fault_status_output_o)) else $error("fault without safe state");
    fault_latch_a: assert property (
        err_cause_o != 3'h0 |=> (err_cause_o & $past(err_cause_o)) == $past(err_cause_o)
    ) else $error("error cause cleared");
    release_one_a: assert property (
        $fell(first_output_relay_o) && fault_status_output_o |-> e1_q != 6'h0
    ) else $error("relay one released without an edge");
    release_two_a: assert property (
        $fell(second_output_relay_o) && fault_status_output_o |-> e2_q != 6'h0
    ) else $error("relay two released without an edge");
    slow_one_a: assert property (
        $rose(first_output_relay_o) |-> gap_q >= (on_thr(sp_sel_i) - 32'h1) * TICK_CYC
    ) else $error("relay one energised too early");
    cover property ($rose(standstill_contact_o));
    cover property ($fell(second_output_relay_o) && fault_status_output_o);
    cover property ($rose(err_cause_o[1]));
endmodule

bind dcsm_top dcsm_props #(.TICK_CYC(TICK_CYC), .SELFTEST_TICKS(SELFTEST_TICKS)) u_props (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .pulse_one_i(pulse_one_i),
    .pulse_two_i(pulse_two_i), .sp_sel_i(sp_sel_i), .ready_o(ready_o),
    .first_output_relay_o(first_output_relay_o), .err_cause_o(err_cause_o),
    .second_output_relay_o(second_output_relay_o), .standstill_contact_o(standstill_contact_o),
    .fault_status_output_o(fault_status_output_o));

//--- testbench/dcsm_sensors.sv
// Two pnp pick-ups facing cams on a moving shaft
`timescale 1ns/10ps
module dcsm_sensors (
    input  wire logic clk_i,  // Clock
    output logic      one_o,  // Pick-up one, high = damped
    output logic      two_o   // Pick-up two, high = damped
);
    initial begin
        one_o = 1'b1;
        two_o = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Gaps never overlap, so one pick-up always stays damped
    task automatic pitch(input int half);
        two_o <= 1'b0;
        hold(half / 2);
        two_o <= 1'b1;
        hold(half / 2);
        one_o <= 1'b0;
        hold(half / 2);
        one_o <= 1'b1;
        hold(half / 2);
    endtask
    // Faulty pick-up two stays damped while one keeps pulsing
    task automatic lose_two(input int n);
        repeat (n) begin
            one_o <= 1'b0;
            hold(8);
            one_o <= 1'b1;
            hold(8);
        end
    endtask
    // Both pick-ups facing a gap at once
    task automatic gap(input int n);
        one_o <= 1'b0;
        two_o <= 1'b0;
        hold(n);
        one_o <= 1'b1;
        two_o <= 1'b1;
        hold(8);
    endtask
endmodule

//--- testbench/tb_dcsm_top.sv
// Self-checking bench for the standstill monitor
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_dcsm_top;
    import dcsm_pkg::*;
    // One cycle per tick keeps the 2 Hz standstill time inside the run
    localparam int unsigned TCK = 1;
    localparam int unsigned STT = 20;
    logic       mclk_i;
    logic       sys_rst_i;
    logic [1:0] sp_sel_i;
    logic       p1;
    logic       p2;
    logic       r1;
    logic       r2;
    logic       stat;
    logic [2:0] err;
    logic       cont;
    logic       rdy;
    logic [5:0] exp_q[$];
    int         n_errors;
    int         compares;

    dcsm_sensors u_sens (.clk_i(mclk_i), .one_o(p1), .two_o(p2));
    dcsm_top #(.TICK_CYC(TCK), .SELFTEST_TICKS(STT)) dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .pulse_one_i(p1), .pulse_two_i(p2),
        .sp_sel_i(sp_sel_i), .first_output_relay_o(r1), .second_output_relay_o(r2),
        .standstill_contact_o(cont), .fault_status_output_o(stat), .ready_o(rdy),
        .err_cause_o(err));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic settle(input int lim);
        for (int i = 0; i < lim && exp_q.size() != 0; i++) @(posedge mclk_i);
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("mismatch at %0t: expected change missing", $time);
            conclude();
        end
    endtask
    task automatic boot(input logic [1:0] sp);
        sys_rst_i <= 1'b1;
        sp_sel_i  <= sp;
        repeat (20) @(posedge mclk_i);
        exp_q.push_back(6'h08);
        sys_rst_i <= 1'b0;
        settle(STT * TCK + 20);
    endtask

    // Every change of relays or status must have been announced by the driver
    initial begin : watch
        logic [2:0] prev;
        logic [5:0] note;
        prev = 3'h0;
        forever begin
            @(posedge mclk_i);
            #1;
            if (sys_rst_i) begin
                prev = {r1, r2, stat};
            end else if ({r1, r2, stat} !== prev) begin
                repeat (2) @(posedge mclk_i);
                #1;
                prev = {r1, r2, stat};
                if (exp_q.size() == 0) begin
                    n_errors++;
                    $display("mismatch at %0t: unexpected output change", $time);
                end else begin
                    note = exp_q.pop_front();
                    `CHK({r1, r2, stat, err}, note)
                    `CHK(cont, note[5] & note[4])
                    `CHK(rdy, note[3])
                end
            end
        end
    end

    initial begin
        sys_rst_i = 1'b1;
        sp_sel_i  = SEL_2HZ;
        n_errors  = 0;
        compares  = 0;
        void'($urandom(32'ha4f1));
        boot(SEL_2HZ);
        exp_q.push_back(6'h38);
        settle(ON_THR3 * TCK + 100);
        u_sens.pitch(10000);
        exp_q.push_back(6'h28);
        exp_q.push_back(6'h08);
        u_sens.pitch(10000);
        settle(100);
        $display("test standstill and release done");
        for (int k = 0; k < 3; k++) begin
            boot(2'(k));
            if (k == 0) begin
                u_sens.lose_two(2);
                exp_q.push_back(6'h01);
                u_sens.lose_two(1);
            end else if (k == 1) begin
                u_sens.gap(198);
                exp_q.push_back(6'h02);
                u_sens.gap(202);
            end else begin
                exp_q.push_back(6'h04);
                sp_sel_i <= SEL_2HZ;
            end
            settle(100);
            // Input activity must not lift a latched fault
            u_sens.pitch(20 + int'($urandom % 40));
            repeat (300) @(posedge mclk_i);
            $display("test fault %0d done", k);
        end
        conclude();
    end
endmodule
